// >>> logic/pdm_status.sv
// pdm_status: always-on domain status/control, transition engine and module status array behind AXI4-Lite.
// assumes synchronous inputs on aclk, an AXI4-Lite master that offers address and data together.
//
// What this block does
// R1 - transition status bit 0 reads 1 while domain modules change state, else 0
// R2 - domain status bit 9 reads 1 once power-on reset finished, 0 before
// R3 - domain status bit 8 shows domain power-on reset: 0 asserted, 1 released
// R4 - domain status bits 4..0 give power state: 0 off, 1 on
// R5 - domain control bit 0 is read/write next state, resets to 1 (on)
// R6 - software always keeps the always-on domain next state at 1
// R7 - exactly one power domain, the always-on domain, is provided
// R8 - forty read-only module status words with emulation, clock, reset and state fields
// R9 - go command moves each domain/module whose next differs to its requested state; module next codes above 3 never move
// R10 - module state 0..3 are the four stable states; 4h and above mean transition
// R11 - clock status bit shows the actual module clock, 1 on, 0 off
// R12 - emulation-altered flags exist only for module 39, zero elsewhere
// R13 - busy rises cycle after go taken, falls once all targets reached
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module pdm_status #(
   parameter int NMOD       = pdm_pkg::NUM_MODULES,
   parameter int TRANS_CYC  = pdm_pkg::TRANS_CYCLES,
   parameter int POR_CYC    = pdm_pkg::POR_CYCLES
) (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [pdm_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output      logic                          s_axi_awready,
   input  wire logic [pdm_pkg::DATA_W-1:0]    s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output      logic                          s_axi_wready,
   output      logic [1:0]                    s_axi_bresp,
   output      logic                          s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [pdm_pkg::ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output      logic                          s_axi_arready,
   output      logic [pdm_pkg::DATA_W-1:0]    s_axi_rdata,
   output      logic [1:0]                    s_axi_rresp,
   output      logic                          s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic                          emu_alter_state,
   input  wire logic                          emu_alter_reset,
   output      logic [NMOD-1:0]               module_clock_on,
   output      logic [NMOD-1:0]               module_reset_released,
   output      logic                          local_reset_released,
   output      logic                          irq
);

   // ==========================================================================
   // state
   localparam int CNT_W = $clog2(TRANS_CYC + POR_CYC + 2);

   pdm_pkg::pdm_engine_t        engine;
   logic [CNT_W-1:0]            trans_cnt;
   logic [CNT_W-1:0]            por_cnt;
   logic [NMOD-1:0]             pending;
   logic                        dom_pending;
   logic                        domain_on;
   logic                        domain_next;
   logic                        por_released;
   logic                        por_done;
   logic [1:0]                  mstate [NMOD];
   logic [2:0]                  mnext  [NMOD];
   logic                        mlrst  [NMOD];
   logic [1:0]                  mie    [NMOD];
   logic                        local_reset_released_done;
   logic [pdm_pkg::IRQ_W-1:0]   irq_status;
   logic [pdm_pkg::IRQ_W-1:0]   irq_mask;

   // ==========================================================================
   // address decode helpers
   function automatic logic mod_hit(input logic [pdm_pkg::ADDR_W-1:0] addr,
                                    input logic [pdm_pkg::ADDR_W-1:0] base);
      logic [pdm_pkg::ADDR_W-1:0] off;
      off = addr - base;
      return (addr >= base) && ({1'b0, off[pdm_pkg::ADDR_W-1:2]} < (pdm_pkg::ADDR_W-1)'(NMOD));
   endfunction

   function automatic logic [5:0] mod_idx(input logic [pdm_pkg::ADDR_W-1:0] addr,
                                          input logic [pdm_pkg::ADDR_W-1:0] base);
      logic [pdm_pkg::ADDR_W-1:0] off;
      off = addr - base;
      return off[7:2];
   endfunction

   function automatic logic reg_hit(input logic [pdm_pkg::ADDR_W-1:0] addr,
                                    input logic [pdm_pkg::ADDR_W-1:0] off);
      return addr[pdm_pkg::ADDR_W-1:2] == off[pdm_pkg::ADDR_W-1:2];
   endfunction

   // one module status word
   function automatic logic [31:0] mdstat_word(input int i);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[pdm_pkg::MST_RSVD_ONE_BIT]  = 1'b1;
      w[pdm_pkg::MST_CLOCK_BIT]     = mstate[i][0];                                // see R11
      w[pdm_pkg::MST_MODULE_RESET_RELEASED_BIT]      = mstate[i][1];
      w[pdm_pkg::MST_LOCAL_RESET_RELEASED_BIT]      = (i == pdm_pkg::EMU_MODULE) ? mlrst[i] : 1'b1;
      w[pdm_pkg::MST_LOCAL_RESET_RELEASED_DONE_BIT] = (i == pdm_pkg::EMU_MODULE) ? local_reset_released_done : 1'b1;
      if (i == pdm_pkg::EMU_MODULE) begin                                          // see R12
         w[pdm_pkg::MST_EMU_STATE_BIT] = irq_status[pdm_pkg::IRQ_EMU_STATE_BIT];
         w[pdm_pkg::MST_EMU_RESET_BIT] = irq_status[pdm_pkg::IRQ_EMU_RESET_BIT];
      end
      if (pending[i] && engine == pdm_pkg::PDM_BUSY) begin
         w[5:0] = pdm_pkg::MSTATE_TRANS;                                           // see R10
      end else begin
         w[5:0] = {4'h0, mstate[i]};                                               // see R10
      end
      return w;                                                                    // see R8
   endfunction

   // ==========================================================================
   // write channel
   wire        wr_fire     = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   wire        wr_b0       = wr_fire && s_axi_wstrb[0];
   wire        wr_b1       = wr_fire && s_axi_wstrb[1];
   wire        wr_cmd      = reg_hit(s_axi_awaddr, pdm_pkg::OFF_CMD);
   wire        wr_dctl     = reg_hit(s_axi_awaddr, pdm_pkg::OFF_DCTL);
   wire        wr_istat    = reg_hit(s_axi_awaddr, pdm_pkg::OFF_ISTAT);
   wire        wr_imask    = reg_hit(s_axi_awaddr, pdm_pkg::OFF_IMASK);
   wire        wr_ro       = reg_hit(s_axi_awaddr, pdm_pkg::OFF_TSTAT) || reg_hit(s_axi_awaddr, pdm_pkg::OFF_DSTAT)
                             || mod_hit(s_axi_awaddr, pdm_pkg::MDSTAT_BASE);
   wire        wr_mctl     = mod_hit(s_axi_awaddr, pdm_pkg::MDCTL_BASE);
   wire [5:0]  wr_idx      = mod_idx(s_axi_awaddr, pdm_pkg::MDCTL_BASE);
   wire        wr_mapped   = wr_cmd || wr_dctl || wr_istat || wr_imask || wr_ro || wr_mctl;
   wire        go_hit      = wr_b0 && wr_cmd && s_axi_wdata[pdm_pkg::CMD_GO_BIT]
                             && engine == pdm_pkg::PDM_IDLE;

   assign s_axi_awready = wr_fire;
   assign s_axi_wready  = wr_fire;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= pdm_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? pdm_pkg::RESP_OKAY : pdm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================================
   // read channel
   wire        rd_fire     = s_axi_arvalid && !s_axi_rvalid;
   wire        rd_mstat    = mod_hit(s_axi_araddr, pdm_pkg::MDSTAT_BASE);
   wire        rd_mctl     = mod_hit(s_axi_araddr, pdm_pkg::MDCTL_BASE);
   wire [5:0]  rd_sidx     = mod_idx(s_axi_araddr, pdm_pkg::MDSTAT_BASE);
   wire [5:0]  rd_cidx     = mod_idx(s_axi_araddr, pdm_pkg::MDCTL_BASE);
   logic [31:0] rd_word;
   logic        rd_ok;

   assign s_axi_arready = rd_fire;

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      if (reg_hit(s_axi_araddr, pdm_pkg::OFF_TSTAT)) begin
         rd_word[pdm_pkg::TSTAT_BUSY_BIT] = (engine == pdm_pkg::PDM_BUSY);       // see R1
      end else if (reg_hit(s_axi_araddr, pdm_pkg::OFF_DSTAT)) begin
         rd_word[pdm_pkg::DSTAT_POR_DONE_BIT] = por_done;                        // see R2
         rd_word[pdm_pkg::DSTAT_POR_BIT]      = por_released;                    // see R3
         rd_word[4:0] = domain_on ? pdm_pkg::DOMAIN_ON : pdm_pkg::DOMAIN_OFF;    // see R4
      end else if (reg_hit(s_axi_araddr, pdm_pkg::OFF_DCTL)) begin
         rd_word[pdm_pkg::DCTL_NEXT_BIT] = domain_next;                          // see R5
      end else if (reg_hit(s_axi_araddr, pdm_pkg::OFF_ISTAT)) begin
         rd_word[pdm_pkg::IRQ_W-1:0] = irq_status;
      end else if (reg_hit(s_axi_araddr, pdm_pkg::OFF_IMASK)) begin
         rd_word[pdm_pkg::IRQ_W-1:0] = irq_mask;
      end else if (reg_hit(s_axi_araddr, pdm_pkg::OFF_CMD)) begin
         rd_word = 32'h0000_0000;
      end else if (rd_mstat) begin
         rd_word = mdstat_word(int'(rd_sidx));                                    // see R8
      end else if (rd_mctl) begin
         rd_word[2:0]                    = mnext[rd_cidx];
         rd_word[pdm_pkg::MCTL_LOCAL_RESET_RELEASED_BIT] = mlrst[rd_cidx];
         rd_word[10:9]                   = mie[rd_cidx];
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= pdm_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_ok ? pdm_pkg::RESP_OKAY : pdm_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================================
   // control registers
   // single domain only; the next bit is stored as written, software must keep it at 1
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         domain_next <= 1'b1;                                                     // see R5, R7
         irq_mask    <= '0;
      end else begin
         if (wr_b0 && wr_dctl) begin
            domain_next <= s_axi_wdata[pdm_pkg::DCTL_NEXT_BIT];                   // see R5, R6
         end
         if (wr_b0 && wr_imask) begin
            irq_mask <= s_axi_wdata[pdm_pkg::IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NMOD; i++) begin
            mnext[i] <= pdm_pkg::MNEXT_RESET;
            mlrst[i] <= 1'b1;
            mie[i]   <= 2'h0;
         end
      end else if (wr_mctl) begin
         if (wr_b0) begin
            mnext[wr_idx] <= s_axi_wdata[2:0];
         end
         if (wr_b1) begin
            mlrst[wr_idx] <= s_axi_wdata[pdm_pkg::MCTL_LOCAL_RESET_RELEASED_BIT];
            mie[wr_idx]   <= s_axi_wdata[10:9];
         end
      end
   end

   // ==========================================================================
   // transition engine
   // a go while busy is dropped; next codes above 3 are not states and never start a move
   function automatic logic wants_move(input int i);
      return (mnext[i][2] == 1'b0) && (mnext[i][1:0] != mstate[i]);
   endfunction

   wire trans_end = (engine == pdm_pkg::PDM_BUSY) && (trans_cnt == '0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         engine      <= pdm_pkg::PDM_IDLE;
         trans_cnt   <= '0;
         pending     <= '0;
         dom_pending <= 1'b0;
         domain_on   <= 1'b1;
      end else begin
         unique case (engine)
            pdm_pkg::PDM_IDLE: begin
               if (go_hit) begin
                  engine      <= pdm_pkg::PDM_BUSY;                               // see R13
                  trans_cnt   <= CNT_W'(TRANS_CYC - 1);
                  dom_pending <= (domain_next != domain_on);                      // see R9
                  for (int i = 0; i < NMOD; i++) begin
                     pending[i] <= wants_move(i);                                 // see R9
                  end
               end
            end
            pdm_pkg::PDM_BUSY: begin
               if (trans_end) begin
                  engine      <= pdm_pkg::PDM_IDLE;                               // see R13
                  pending     <= '0;
                  dom_pending <= 1'b0;
                  if (dom_pending) begin
                     domain_on <= domain_next;                                    // see R9
                  end
               end else begin
                  trans_cnt <= trans_cnt - CNT_W'(1);
               end
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NMOD; i++) begin
            mstate[i] <= pdm_pkg::MSTATE_RESET;
         end
      end else if (trans_end) begin
         for (int i = 0; i < NMOD; i++) begin
            if (pending[i]) begin
               mstate[i] <= mnext[i][1:0];                                        // see R9
            end
         end
      end
   end

   // ==========================================================================
   // power-on reset and local reset status
   // the released flag lags the bus reset by one edge so software never sees it early
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         por_released <= 1'b0;
         por_done     <= 1'b0;
         por_cnt      <= '0;
         local_reset_released_done    <= 1'b0;
      end else begin
         por_released <= 1'b1;                                                    // see R3
         if (por_cnt == CNT_W'(POR_CYC)) begin
            por_done <= 1'b1;                                                     // see R2
         end else begin
            por_cnt <= por_cnt + CNT_W'(1);
         end
         local_reset_released_done <= mlrst[pdm_pkg::EMU_MODULE] && mstate[pdm_pkg::EMU_MODULE][1];
      end
   end

   // ==========================================================================
   // interrupts: sticky, write one to clear, a new event beats the clear
   logic [pdm_pkg::IRQ_W-1:0] irq_set;
   wire  [pdm_pkg::IRQ_W-1:0] irq_clr = (wr_b0 && wr_istat) ? s_axi_wdata[pdm_pkg::IRQ_W-1:0] : '0;

   always_comb begin
      irq_set = '0;
      irq_set[pdm_pkg::IRQ_DONE_BIT]      = trans_end;
      irq_set[pdm_pkg::IRQ_EMU_STATE_BIT] = emu_alter_state;                     // see R12
      irq_set[pdm_pkg::IRQ_EMU_RESET_BIT] = emu_alter_reset;                     // see R12
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ==========================================================================
   // module outputs straight from state flops
   always_comb begin
      for (int i = 0; i < NMOD; i++) begin
         module_clock_on[i]       = mstate[i][0];                                 // see R11
         module_reset_released[i] = mstate[i][1];
      end
   end

   assign local_reset_released = mlrst[pdm_pkg::EMU_MODULE];

endmodule // pdm_status

// >>> logic/pdm_pkg.sv
// pdm_pkg: register map, field positions, codes and timing of the power domain and module status block.
// assumes one 40 MHz clock and an AXI4-Lite register bus with 32-bit data.
package pdm_pkg;

   // ==========================================================================
   // bus and register map (byte addresses)
   localparam int              ADDR_W        = 12;
   localparam int              DATA_W        = 32;
   localparam logic [11:0]     OFF_CMD       = 12'h000;
   localparam logic [11:0]     OFF_TSTAT     = 12'h004;
   localparam logic [11:0]     OFF_DSTAT     = 12'h008;
   localparam logic [11:0]     OFF_DCTL      = 12'h00C;
   localparam logic [11:0]     OFF_ISTAT     = 12'h010;
   localparam logic [11:0]     OFF_IMASK     = 12'h014;
   localparam logic [11:0]     MDSTAT_BASE   = 12'h100;
   localparam logic [11:0]     MDCTL_BASE    = 12'h200;
   localparam logic [1:0]      RESP_OKAY     = 2'h0;
   localparam logic [1:0]      RESP_SLVERR   = 2'h2;

   // ==========================================================================
   // field positions
   localparam int CMD_GO_BIT         = 0;
   localparam int TSTAT_BUSY_BIT     = 0;
   localparam int DSTAT_POR_DONE_BIT = 9;
   localparam int DSTAT_POR_BIT      = 8;
   localparam int DCTL_NEXT_BIT      = 0;
   localparam int MST_EMU_STATE_BIT  = 17;
   localparam int MST_EMU_RESET_BIT  = 16;
   localparam int MST_CLOCK_BIT      = 12;
   localparam int MST_RSVD_ONE_BIT   = 11;
   localparam int MST_MODULE_RESET_RELEASED_BIT       = 10;
   localparam int MST_LOCAL_RESET_RELEASED_DONE_BIT  = 9;
   localparam int MST_LOCAL_RESET_RELEASED_BIT       = 8;
   localparam int MCTL_LOCAL_RESET_RELEASED_BIT      = 8;
   localparam int IRQ_DONE_BIT       = 0;
   localparam int IRQ_EMU_STATE_BIT  = 1;
   localparam int IRQ_EMU_RESET_BIT  = 2;
   localparam int IRQ_W              = 3;

   // ==========================================================================
   // codes and reset values
   localparam logic [4:0]      DOMAIN_OFF    = 5'h00;
   localparam logic [4:0]      DOMAIN_ON     = 5'h01;
   localparam logic [5:0]      MSTATE_TRANS  = 6'h04;
   localparam logic [1:0]      MSTATE_RESET  = 2'h0;
   localparam logic [2:0]      MNEXT_RESET   = 3'h0;
   localparam int              NUM_MODULES   = 40;
   localparam int              EMU_MODULE    = 39;
   typedef enum logic {PDM_IDLE, PDM_BUSY} pdm_engine_t;

   // ==========================================================================
   // timing
   localparam int CLK_PERIOD_NS  = 25;
   localparam int TRANS_TIME_NS  = 100;
   localparam int POR_TIME_NS    = 250;
   localparam int TRANS_CYCLES   = (TRANS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POR_CYCLES     = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// >>> verification/pdm_status_chk.sv
// pdm_status_chk: port-level assertions for the power domain and module status block.
// assumes the default 40-module build and one aclk domain.
`timescale 1ns/1ps
module pdm_status_chk #(
   parameter int NMOD = 40
) (
   input wire logic                          aclk,
   input wire logic                          aresetn,
   input wire logic [pdm_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input wire logic                          s_axi_awvalid,
   input wire logic                          s_axi_awready,
   input wire logic [pdm_pkg::DATA_W-1:0]    s_axi_wdata,
   input wire logic [3:0]                    s_axi_wstrb,
   input wire logic                          s_axi_wvalid,
   input wire logic                          s_axi_wready,
   input wire logic [1:0]                    s_axi_bresp,
   input wire logic                          s_axi_bvalid,
   input wire logic                          s_axi_bready,
   input wire logic [pdm_pkg::ADDR_W-1:0]    s_axi_araddr,
   input wire logic                          s_axi_arvalid,
   input wire logic                          s_axi_arready,
   input wire logic [pdm_pkg::DATA_W-1:0]    s_axi_rdata,
   input wire logic [1:0]                    s_axi_rresp,
   input wire logic                          s_axi_rvalid,
   input wire logic                          s_axi_rready,
   input wire logic                          emu_alter_state,
   input wire logic                          emu_alter_reset,
   input wire logic [NMOD-1:0]               module_clock_on,
   input wire logic [NMOD-1:0]               module_reset_released,
   input wire logic                          local_reset_released,
   input wire logic                          irq
);
   // ==========================================================================
   // bus handshake and reset state
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wr_take; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid; endproperty
   a_wr_take: assert property (p_wr_take) else $error("write response missing");
   property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
   property p_rd_take; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
   a_rd_take: assert property (p_rd_take) else $error("read data missing");
   property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
   property p_awready; s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid); endproperty
   a_awready: assert property (p_awready) else $error("awready wrong");
   property p_wready; s_axi_wready == s_axi_awready; endproperty
   a_wready: assert property (p_wready) else $error("wready wrong");
   property p_arready; s_axi_arready == (s_axi_arvalid && !s_axi_rvalid); endproperty
   a_arready: assert property (p_arready) else $error("arready wrong");
   // reset check must not be masked by the reset itself
   property p_reset; disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && local_reset_released;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule // pdm_status_chk
bind pdm_status pdm_status_chk #(.NMOD(NMOD)) u_pdm_status_chk (.*);

// >>> verification/tb_pdm_status.sv
// tb_pdm_status: self-checking bench over AXI4-Lite for the domain and module status block.
// assumes pdm_pkg and pdm_status compiled first; bready/rready held high throughout.
`timescale 1ns/1ps
module tb_pdm_status;
   localparam int POR = 6;
   localparam int TRN = 8;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1, emu_alter_state = 1'b0, emu_alter_reset = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, local_reset_released, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [39:0] module_clock_on, module_reset_released;
   logic [31:0] seed = 32'h0001_3890;
   int          miscompares = 0, checks_done = 0;
   always #12.5 aclk = ~aclk;
   pdm_status #(.TRANS_CYC(TRN), .POR_CYC(POR)) u_pdm_status (.*);
   // ==========================================================================
   // helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] mexp(input int n, input logic [5:0] st);
      logic [31:0] v;
      v = 32'h0000_0900 | 32'(st);
      v[12] = st[0];
      v[10] = st[1];
      v[9] = (n != 39) || st[1];
      return v;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // no ready wait is assumed: bounded only as a hang guard
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      int t;
      t = 0;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      do begin @(posedge aclk); t++; end while (s_axi_awready !== 1'b1 && t < 50);
      s_axi_awvalid <= 1'b0; s_axi_wvalid <= 1'b0;
      do begin @(posedge aclk); t++; end while (s_axi_bvalid !== 1'b1 && t < 50);
      r = s_axi_bresp;
      chk("write_done", 32'h1, 32'(t < 50));
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int t;
      t = 0;
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
      do begin @(posedge aclk); t++; end while (s_axi_arready !== 1'b1 && t < 50);
      s_axi_arvalid <= 1'b0;
      do begin @(posedge aclk); t++; end while (s_axi_rvalid !== 1'b1 && t < 50);
      d = s_axi_rdata; r = s_axi_rresp;
      chk("read_done", 32'h1, 32'(t < 50));
   endtask
   task automatic give_verdict();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #500000;
      miscompares++;
      give_verdict();
   end
   // ==========================================================================
   // main sequence
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [5:0]  st;
      logic [5:0]  cur [40];
      int          n, t;
      foreach (cur[i]) cur[i] = 6'h00;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(pdm_pkg::OFF_DSTAT, d, r); chk("dstat_early", 32'h0000_0101, d);
      rd(pdm_pkg::OFF_TSTAT, d, r); chk("tstat_idle", 32'h0, d);
      repeat (POR + 2) @(posedge aclk);
      rd(pdm_pkg::OFF_DSTAT, d, r); chk("dstat_por", 32'h0000_0301, d);
      rd(pdm_pkg::OFF_DCTL, d, r); chk("dctl_reset", 32'h1, d);
      chk("local_reset_released_rst", 32'h1, 32'(local_reset_released));
      seed = lfsr_next(seed);
      wr(pdm_pkg::OFF_DSTAT, seed, 4'hF, r); chk("ro_resp", 32'(pdm_pkg::RESP_OKAY), 32'(r));
      rd(pdm_pkg::OFF_DSTAT, d, r); chk("dstat_ro", 32'h0000_0301, d);
      wr(pdm_pkg::OFF_DCTL, 32'h0, 4'h0, r); rd(pdm_pkg::OFF_DCTL, d, r); chk("dctl_strb", 32'h1, d);
      wr(12'h018, 32'h1, 4'hF, r); chk("wr_unmapped", 32'(pdm_pkg::RESP_SLVERR), 32'(r));
      rd(12'h018, d, r); chk("rd_unmapped", 32'(pdm_pkg::RESP_SLVERR), 32'(r));
      chk("rd_unmapped_data", 32'h0, d);
      for (int i = 0; i < 40; i++) begin
         rd(pdm_pkg::MDSTAT_BASE + 12'(4 * i), d, r); chk("mdstat_reset", mexp(i, 6'h00), d);
      end
      wr(pdm_pkg::OFF_IMASK, 32'h1, 4'hF, r);
      for (int k = 0; k < 4; k++) begin
         seed = lfsr_next(seed);
         n = (k == 0) ? 39 : int'(seed % 39);
         st = (k == 0) ? 6'h03 : 6'(seed[9:8]);
         if (st == cur[n]) st = st ^ 6'h01;
         wr(pdm_pkg::MDCTL_BASE + 12'(4 * n), 32'h100 | 32'(st), 4'h3, r);
         wr(pdm_pkg::OFF_CMD, 32'h1, 4'h1, r);
         rd(pdm_pkg::OFF_TSTAT, d, r); chk("busy", 32'h1, d);
         rd(pdm_pkg::MDSTAT_BASE + 12'(4 * n), d, r); chk("mid_state", 32'(pdm_pkg::MSTATE_TRANS), 32'(d[5:0]));
         t = 0;
         do begin rd(pdm_pkg::OFF_TSTAT, d, r); t++; end while (d !== 32'h0 && t < 20);
         chk("idle_again", 32'h0, d);
         cur[n] = st;
         rd(pdm_pkg::MDSTAT_BASE + 12'(4 * n), d, r); chk("new_state", mexp(n, st), d);
         chk("clk_pin", 32'(st[0]), 32'(module_clock_on[n]));
         chk("rst_pin", 32'(st[1]), 32'(module_reset_released[n]));
         chk("irq_done", 32'h1, 32'(irq));
         wr(pdm_pkg::OFF_ISTAT, 32'h1, 4'hF, r); chk("irq_clr", 32'h0, 32'(irq));
         rd(pdm_pkg::OFF_DSTAT, d, r); chk("domain_on", 32'h0000_0301, d);
      end
      wr(pdm_pkg::MDCTL_BASE, 32'h104, 4'h3, r); wr(pdm_pkg::OFF_CMD, 32'h1, 4'h1, r);
      rd(pdm_pkg::MDSTAT_BASE, d, r); chk("no_move", 32'(cur[0]), 32'(d[5:0]));
      wr(pdm_pkg::OFF_IMASK, 32'h0, 4'hF, r);
      emu_alter_state <= 1'b1; @(posedge aclk); emu_alter_state <= 1'b0; @(posedge aclk);
      chk("irq_masked", 32'h0, 32'(irq));
      rd(pdm_pkg::MDSTAT_BASE + 12'h09C, d, r); chk("emu_state_39", 32'h1, 32'(d[17]));
      rd(pdm_pkg::MDSTAT_BASE, d, r); chk("emu_mod0", 32'h0, 32'(d[17:16]));
      wr(pdm_pkg::OFF_IMASK, 32'h6, 4'hF, r); chk("irq_emu", 32'h1, 32'(irq));
      wr(pdm_pkg::OFF_ISTAT, 32'h6, 4'hF, r); chk("irq_emu_clr", 32'h0, 32'(irq));
      emu_alter_reset <= 1'b1; @(posedge aclk); emu_alter_reset <= 1'b0; @(posedge aclk);
      rd(pdm_pkg::MDSTAT_BASE + 12'h09C, d, r); chk("emu_reset_39", 32'h1, 32'(d[16]));
      chk("irq_emu_rst", 32'h1, 32'(irq));
      wr(pdm_pkg::MDCTL_BASE + 12'h09C, 32'h0, 4'h2, r);
      rd(pdm_pkg::MDSTAT_BASE + 12'h09C, d, r); chk("local_reset_released_39", 32'h0, 32'(d[9:8]));
      chk("local_reset_released_pin", 32'h0, 32'(local_reset_released)); chk("rresp", 32'h0, 32'(r));
      give_verdict();
   end
endmodule // tb_pdm_status
